//--- core/crf_consts.svh
// Constants for the processor register file and condition flags block.
`ifndef CRF_CONSTS_SVH
`define CRF_CONSTS_SVH

// Register byte offsets on the bus, one aligned word each.
`define CRF_OFS_ACC 8'h00
`define CRF_OFS_INDEX 8'h04
`define CRF_OFS_FLAGS 8'h08
`define CRF_OFS_STATUS 8'h0c

// Bit positions inside the condition_code_flags register.
`define CRF_CC_V 7
`define CRF_CC_H 4
`define CRF_CC_I 3
`define CRF_CC_N 2
`define CRF_CC_Z 1
`define CRF_CC_C 0

// Bit positions inside the status register.
`define CRF_STAT_INHIBIT 0
`define CRF_STAT_PENDING 1

// Reset values.
`define CRF_RST_INDEX_HI 8'h00
`define CRF_RST_FLAGS 8'h08

// Decimal adjust constants.
`define CRF_BCD_FIX_LO 8'h06
`define CRF_BCD_FIX_HI 8'h60
`define CRF_BCD_MAX_LO 4'h9
`define CRF_BCD_MAX 8'h99

// Bus responses.
`define CRF_RESP_OKAY 2'b00
`define CRF_RESP_SLVERR 2'b10

`endif

//--- core/crf_pkg.sv
// Types shared by the processor register file and condition flags block.
package crf_pkg;

  // Operations that the execute stage hands to the register file.
  typedef enum logic [4:0] {
    CRF_NOP, CRF_LDA, CRF_STA, CRF_ADD, CRF_ADC, CRF_SUB, CRF_SBC, CRF_AND,
    CRF_ORA, CRF_EOR, CRF_LDX, CRF_STX, CRF_LDHX, CRF_STHX, CRF_CLRX, CRF_INCX,
    CRF_DECX, CRF_COMX, CRF_NEGX, CRF_LSLX, CRF_LSRX, CRF_ROLX, CRF_RORX, CRF_TAX,
    CRF_TXA, CRF_DECADJ, CRF_UNMASK, CRF_SEI, CRF_TAP, CRF_TPA, CRF_BTST
  } crf_opc_t;

  // Addressing modes for operand and destination location.
  typedef enum logic [1:0] {
    CRF_MODE_DIRECT, CRF_MODE_EXTENDED, CRF_MODE_INDEXED, CRF_MODE_INDEXED_OFS
  } crf_mode_t;

  // Signed compare branches.
  typedef enum logic [1:0] {
    CRF_BR_GREATER, CRF_BR_GREATER_EQUAL, CRF_BR_LESS_EQUAL, CRF_BR_LESS
  } crf_brc_t;

  // Register select from bus address decode.
  typedef enum logic [2:0] {
    CRF_SEL_ACC, CRF_SEL_INDEX, CRF_SEL_FLAGS, CRF_SEL_STATUS, CRF_SEL_NONE
  } crf_sel_t;

  // One operation word from the execute stage.
  typedef struct packed {
    crf_opc_t opc;
    logic [15:0] data;
    logic [15:0] offset;
    logic [2:0] bit_sel;
    crf_mode_t src_mode;
    crf_mode_t dst_mode;
  } crf_op_t;

endpackage

//--- core/crf_regs.sv
// Programmer-visible processor registers, condition flags and a bus slave.
//
// What this block does
// - Eight-bit accumulator feeds the arithmetic unit, takes results, reset leaves it.
// - Reset forces the upper index byte to zero.
// - Reset leaves the lower index byte unchanged.
// - Indexed addresses use the whole sixteen-bit index pair, upper byte high.
// - Some legacy operations touch only the lower index byte.
// - Lower index byte clears, increments, decrements, complements, negates, shifts, rotates.
// - Flag bit seven shows two's complement overflow.
// - Signed compare branches use the overflow flag.
// - Flag bit four shows carry from bit three into bit four on adds.
// - Decimal adjust uses half-carry and carry to correct a BCD sum.
// - Flag bit three set masks maskable interrupts; clear enables them.
// - Interrupt mask is set after registers are stacked, before service fetch.
// - No interrupt at the boundary after a mask-clearing or flags transfer.
// - Flag bit two follows the result's top bit, loads and stores included.
// - Flag bit one is set for an all-zero eight or sixteen bit result.
// - Flag bit zero is carry or borrow, also set by bit test and shifts.
// - One linear sixteen-bit address space for memory, control and I/O.
// - Moves take source and destination addresses from independent modes.
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "crf_consts.svh"

module crf_regs (
  // Clock, reset and enable.
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire logic I_CE,
  // Operation port from the execute stage.
  input wire logic I_OP_VALID,
  input wire crf_pkg::crf_op_t I_OP,
  input wire crf_pkg::crf_brc_t I_BR_COND,
  // Interrupt sequencing.
  input wire logic I_BOUNDARY,
  input wire logic I_IRQ_REQ,
  input wire logic I_REGS_STACKED,
  // Register and address outputs.
  output logic [7:0] O_ACC,
  output logic [15:0] O_INDEX,
  output logic [7:0] O_FLAGS,
  output logic [15:0] O_SRC_ADDR,
  output logic [15:0] O_DST_ADDR,
  output logic O_BRANCH_TAKE,
  output logic O_IRQ_TAKE,
  // AXI4-Lite write channels.
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  // AXI4-Lite read channels.
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [7:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP
);
  import crf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Functions.

  // Refresh negative and zero flags from an eight-bit result.
  function automatic logic [7:0] set_nz(input logic [7:0] f, input logic [7:0] r);
    logic [7:0] o;
    o = f;
    o[`CRF_CC_N] = r[7];
    o[`CRF_CC_Z] = (r == 8'h00);
    return o;
  endfunction

  // Merge a bus write into an old word under byte strobes.
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] o;
    o = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        o[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return o;
  endfunction

  // Map a bus address onto a register select.
  function automatic crf_sel_t decode(input logic [7:0] a);
    crf_sel_t s;
    unique case ({a[7:2], 2'b00})
      `CRF_OFS_ACC: s = CRF_SEL_ACC;
      `CRF_OFS_INDEX: s = CRF_SEL_INDEX;
      `CRF_OFS_FLAGS: s = CRF_SEL_FLAGS;
      `CRF_OFS_STATUS: s = CRF_SEL_STATUS;
      default: s = CRF_SEL_NONE;
    endcase
    return s;
  endfunction

  // Resolve one addressing mode into a linear sixteen-bit address.
  function automatic logic [15:0] ea(input crf_mode_t m, input logic [15:0] hx,
                                     input logic [15:0] ofs);
    logic [15:0] o;
    unique case (m)
      CRF_MODE_DIRECT: o = {8'h00, ofs[7:0]};
      CRF_MODE_EXTENDED: o = ofs;
      CRF_MODE_INDEXED: o = hx;
      CRF_MODE_INDEXED_OFS: o = hx + ofs;
    endcase
    return o;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  logic [7:0] acc_reg;
  logic [7:0] x_lo_reg;
  logic [7:0] x_hi_reg;
  logic [7:0] cc_reg;
  logic inhibit_reg;
  logic [15:0] src_addr_reg;
  logic [15:0] dst_addr_reg;
  logic [7:0] acc_next;
  logic [7:0] x_lo_next;
  logic [7:0] x_hi_next;
  logic [7:0] cc_next;
  logic [31:0] merged;
  logic inhibit_next;
  logic op_fire;
  logic [8:0] sum;
  logic [7:0] res;
  logic cin;
  logic nv;
  logic lo_fix;
  logic hi_fix;

  // Bus slave state.
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic commit;
  crf_sel_t wsel;
  logic [31:0] rd_word;

  assign op_fire = I_CE & I_OP_VALID;
  assign commit = I_CE & aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wsel = decode(awaddr_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Execute: next register values for one operation.

  // Operations take priority over a bus write landing in the same cycle.
  always_comb begin
    acc_next = acc_reg;
    x_lo_next = x_lo_reg;
    x_hi_next = x_hi_reg;
    cc_next = cc_reg;
    inhibit_next = 1'b0;
    sum = 9'h000;
    res = 8'h00;
    cin = 1'b0;
    lo_fix = 1'b0;
    hi_fix = 1'b0;
    // The merged word is kept whole so that each register takes its own slice.
    unique case (wsel)
      CRF_SEL_ACC: merged = wmerge({24'h0, acc_reg}, wdata_reg, wstrb_reg);
      CRF_SEL_FLAGS: merged = wmerge({24'h0, cc_reg}, wdata_reg, wstrb_reg);
      CRF_SEL_INDEX, CRF_SEL_STATUS, CRF_SEL_NONE: begin
        merged = wmerge({16'h0, x_hi_reg, x_lo_reg}, wdata_reg, wstrb_reg);
      end
    endcase
    if (commit) begin
      unique case (wsel)
        CRF_SEL_ACC: acc_next = merged[7:0];
        CRF_SEL_INDEX: {x_hi_next, x_lo_next} = merged[15:0];
        CRF_SEL_FLAGS: cc_next = merged[7:0];
        CRF_SEL_STATUS, CRF_SEL_NONE: ;
      endcase
    end
    if (op_fire) begin
      cin = cc_reg[`CRF_CC_C] & (I_OP.opc == CRF_ADC || I_OP.opc == CRF_SBC);
      unique case (I_OP.opc)
        CRF_NOP: ;
        CRF_LDA, CRF_AND, CRF_ORA, CRF_EOR: begin
          unique case (I_OP.opc)
            CRF_AND: res = acc_reg & I_OP.data[7:0];
            CRF_ORA: res = acc_reg | I_OP.data[7:0];
            CRF_EOR: res = acc_reg ^ I_OP.data[7:0];
            default: res = I_OP.data[7:0];
          endcase
          acc_next = res;
          cc_next = set_nz(cc_reg, res);
          cc_next[`CRF_CC_V] = 1'b0;
        end
        CRF_STA, CRF_STX: begin
          res = (I_OP.opc == CRF_STA) ? acc_reg : x_lo_reg;
          cc_next = set_nz(cc_reg, res);
          cc_next[`CRF_CC_V] = 1'b0;
        end
        CRF_ADD, CRF_ADC: begin
          sum = {1'b0, acc_reg} + {1'b0, I_OP.data[7:0]} + {8'h00, cin};
          res = sum[7:0];
          acc_next = res;
          cc_next = set_nz(cc_reg, res);
          cc_next[`CRF_CC_C] = sum[8];
          cc_next[`CRF_CC_H] = acc_reg[4] ^ I_OP.data[4] ^ res[4];
          cc_next[`CRF_CC_V] = (acc_reg[7] ~^ I_OP.data[7]) & (res[7] ^ acc_reg[7]);
        end
        CRF_SUB, CRF_SBC: begin
          sum = {1'b0, acc_reg} - {1'b0, I_OP.data[7:0]} - {8'h00, cin};
          res = sum[7:0];
          acc_next = res;
          cc_next = set_nz(cc_reg, res);
          cc_next[`CRF_CC_C] = sum[8];
          cc_next[`CRF_CC_V] = (acc_reg[7] ^ I_OP.data[7]) & (res[7] ^ acc_reg[7]);
        end
        CRF_LDX: begin
          x_lo_next = I_OP.data[7:0];
          cc_next = set_nz(cc_reg, I_OP.data[7:0]);
          cc_next[`CRF_CC_V] = 1'b0;
        end
        CRF_LDHX, CRF_STHX: begin
          if (I_OP.opc == CRF_LDHX) begin
            {x_hi_next, x_lo_next} = I_OP.data;
          end
          res = (I_OP.opc == CRF_LDHX) ? I_OP.data[15:8] : x_hi_reg;
          cc_next[`CRF_CC_N] = res[7];
          cc_next[`CRF_CC_Z] = (I_OP.opc == CRF_LDHX) ? (I_OP.data == 16'h0000)
                                                     : ({x_hi_reg, x_lo_reg} == 16'h0000);
          cc_next[`CRF_CC_V] = 1'b0;
        end
        CRF_CLRX, CRF_INCX, CRF_DECX, CRF_COMX, CRF_NEGX,
        CRF_LSLX, CRF_LSRX, CRF_ROLX, CRF_RORX: begin
          // The upper index byte is never touched here.
          unique case (I_OP.opc)
            CRF_CLRX: res = 8'h00;
            CRF_INCX: res = x_lo_reg + 8'h01;
            CRF_DECX: res = x_lo_reg - 8'h01;
            CRF_COMX: res = ~x_lo_reg;
            CRF_NEGX: res = 8'h00 - x_lo_reg;
            CRF_LSLX: res = {x_lo_reg[6:0], 1'b0};
            CRF_LSRX: res = {1'b0, x_lo_reg[7:1]};
            CRF_ROLX: res = {x_lo_reg[6:0], cc_reg[`CRF_CC_C]};
            default: res = {cc_reg[`CRF_CC_C], x_lo_reg[7:1]};
          endcase
          x_lo_next = res;
          cc_next = set_nz(cc_reg, res);
          unique case (I_OP.opc)
            CRF_CLRX: cc_next[`CRF_CC_V] = 1'b0;
            CRF_INCX: cc_next[`CRF_CC_V] = (res == 8'h80);
            CRF_DECX: cc_next[`CRF_CC_V] = (res == 8'h7f);
            CRF_COMX: begin
              cc_next[`CRF_CC_V] = 1'b0;
              cc_next[`CRF_CC_C] = 1'b1;
            end
            CRF_NEGX: begin
              cc_next[`CRF_CC_V] = (res == 8'h80);
              cc_next[`CRF_CC_C] = (res != 8'h00);
            end
            CRF_LSLX, CRF_ROLX: begin
              cc_next[`CRF_CC_C] = x_lo_reg[7];
              cc_next[`CRF_CC_V] = res[7] ^ x_lo_reg[7];
            end
            default: begin
              cc_next[`CRF_CC_C] = x_lo_reg[0];
              cc_next[`CRF_CC_V] = res[7] ^ x_lo_reg[0];
            end
          endcase
        end
        CRF_TAX: x_lo_next = acc_reg;
        CRF_TXA: acc_next = x_lo_reg;
        CRF_DECADJ: begin
          // A BCD correction only makes sense straight after an add.
          lo_fix = cc_reg[`CRF_CC_H] | (acc_reg[3:0] > `CRF_BCD_MAX_LO);
          hi_fix = cc_reg[`CRF_CC_C] | (acc_reg > `CRF_BCD_MAX);
          res = acc_reg + (hi_fix ? `CRF_BCD_FIX_HI : 8'h00) + (lo_fix ? `CRF_BCD_FIX_LO : 8'h00);
          acc_next = res;
          cc_next = set_nz(cc_reg, res);
          cc_next[`CRF_CC_C] = hi_fix;
        end
        CRF_UNMASK: begin
          cc_next[`CRF_CC_I] = 1'b0;
          inhibit_next = 1'b1;
        end
        CRF_SEI: cc_next[`CRF_CC_I] = 1'b1;
        CRF_TAP: begin
          cc_next = acc_reg;
          inhibit_next = 1'b1;
        end
        CRF_TPA: acc_next = cc_reg;
        CRF_BTST: cc_next[`CRF_CC_C] = I_OP.data[I_OP.bit_sel];
      endcase
    end
    if (I_CE & I_REGS_STACKED) begin
      cc_next[`CRF_CC_I] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register updates.

  // Accumulator and lower index byte carry no reset: they keep their value.
  always_ff @(posedge I_CLOCK) begin
    if (I_CE) begin
      acc_reg <= acc_next;
      x_lo_reg <= x_lo_next;
    end
  end

  // Upper index byte is the only data register that reset clears.
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      x_hi_reg <= `CRF_RST_INDEX_HI;
    end else if (I_CE) begin
      x_hi_reg <= x_hi_next;
    end
  end

  // Flags come out of reset with maskable interrupts held off.
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      cc_reg <= `CRF_RST_FLAGS;
    end else if (I_CE) begin
      cc_reg <= cc_next;
    end
  end

  // Inhibit lasts until the next instruction boundary has passed.
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      inhibit_reg <= 1'b0;
    end else if (I_CE) begin
      if (inhibit_next) begin
        inhibit_reg <= 1'b1;
      end else if (I_BOUNDARY) begin
        inhibit_reg <= 1'b0;
      end
    end
  end

  // Source and destination addresses resolve independently for moves.
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      src_addr_reg <= 16'h0000;
      dst_addr_reg <= 16'h0000;
    end else if (op_fire) begin
      src_addr_reg <= ea(I_OP.src_mode, {x_hi_reg, x_lo_reg}, I_OP.offset);
      dst_addr_reg <= ea(I_OP.dst_mode, {x_hi_reg, x_lo_reg}, I_OP.offset);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Branch and interrupt decisions.

  assign nv = cc_reg[`CRF_CC_N] ^ cc_reg[`CRF_CC_V];

  // Signed branches look at overflow through the N xor V term.
  always_comb begin
    unique case (I_BR_COND)
      CRF_BR_GREATER: O_BRANCH_TAKE = ~(cc_reg[`CRF_CC_Z] | nv);
      CRF_BR_GREATER_EQUAL: O_BRANCH_TAKE = ~nv;
      CRF_BR_LESS_EQUAL: O_BRANCH_TAKE = cc_reg[`CRF_CC_Z] | nv;
      CRF_BR_LESS: O_BRANCH_TAKE = nv;
    endcase
  end

  // Interrupt accepted only at a boundary, unmasked and not inhibited.
  assign O_IRQ_TAKE = I_CE & I_BOUNDARY & I_IRQ_REQ & ~cc_reg[`CRF_CC_I] & ~inhibit_reg;

  assign O_ACC = acc_reg;
  assign O_INDEX = {x_hi_reg, x_lo_reg};
  assign O_FLAGS = cc_reg;
  assign O_SRC_ADDR = src_addr_reg;
  assign O_DST_ADDR = dst_addr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  assign O_AWREADY = ~aw_held_reg & ~bvalid_reg;
  assign O_WREADY = ~w_held_reg & ~bvalid_reg;
  assign O_BVALID = bvalid_reg;
  assign O_BRESP = bresp_reg;
  assign O_ARREADY = ~rvalid_reg;
  assign O_RVALID = rvalid_reg;
  assign O_RDATA = rdata_reg;
  assign O_RRESP = rresp_reg;

  // Address and data are caught in either order; the write lands once both are in.
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `CRF_RESP_OKAY;
    end else if (I_CE) begin
      if (I_AWVALID & O_AWREADY) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= I_AWADDR;
      end
      if (I_WVALID & O_WREADY) begin
        w_held_reg <= 1'b1;
        wdata_reg <= I_WDATA;
        wstrb_reg <= I_WSTRB;
      end
      if (commit) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (wsel == CRF_SEL_NONE) ? `CRF_RESP_SLVERR : `CRF_RESP_OKAY;
      end else if (bvalid_reg & I_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read data word for the addressed register.
  always_comb begin
    rd_word = 32'h0;
    unique case (decode(I_ARADDR))
      CRF_SEL_ACC: rd_word = {24'h0, acc_reg};
      CRF_SEL_INDEX: rd_word = {16'h0, x_hi_reg, x_lo_reg};
      CRF_SEL_FLAGS: rd_word = {24'h0, cc_reg};
      CRF_SEL_STATUS: begin
        rd_word[`CRF_STAT_INHIBIT] = inhibit_reg;
        rd_word[`CRF_STAT_PENDING] = I_IRQ_REQ & ~cc_reg[`CRF_CC_I];
      end
      CRF_SEL_NONE: rd_word = 32'h0;
    endcase
  end

  // Read answer is registered one cycle after the address is taken.
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `CRF_RESP_OKAY;
    end else if (I_CE) begin
      if (I_ARVALID & O_ARREADY) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= (decode(I_ARADDR) == CRF_SEL_NONE) ? `CRF_RESP_SLVERR : `CRF_RESP_OKAY;
      end else if (rvalid_reg & I_RREADY) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  a_reset_hi_zero: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    $fell(I_SYS_RST) |-> x_hi_reg == 8'h00)
    else $error("Upper index byte not zero after reset.");

  a_add_carry_flag: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    op_fire && I_OP.opc == CRF_ADD && !I_REGS_STACKED
      |=> cc_reg[0] == ({1'b0, $past(acc_reg)} + {1'b0, $past(I_OP.data[7:0])} > 9'h0ff))
    else $error("Carry flag wrong after add.");

  a_add_half_carry: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    op_fire && I_OP.opc == CRF_ADD
      |=> cc_reg[4] == ({1'b0, $past(acc_reg[3:0])} + {1'b0, $past(I_OP.data[3:0])} > 5'h0f))
    else $error("Half-carry flag wrong after add.");

  a_load_zero_neg: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    op_fire && I_OP.opc == CRF_LDA
      |=> cc_reg[1] == (acc_reg == 8'h00) && cc_reg[2] == acc_reg[7])
    else $error("Zero or negative flag wrong after load.");

  a_stack_sets_mask: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    I_CE && I_REGS_STACKED |=> cc_reg[3])
    else $error("Mask not set after registers were stacked.");

  a_unmask_inhibit: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    op_fire && I_OP.opc inside {CRF_UNMASK, CRF_TAP} |=> inhibit_reg && !O_IRQ_TAKE)
    else $error("Interrupt taken right after mask clear.");

  a_mask_blocks_irq: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    cc_reg[3] |-> !O_IRQ_TAKE)
    else $error("Interrupt taken while masked.");

  a_legacy_keeps_hi: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    op_fire && I_OP.opc inside {CRF_TAX, CRF_INCX, CRF_LSLX} && !commit |=> $stable(x_hi_reg))
    else $error("Upper index byte changed by a byte-wide index operation.");

  a_indexed_addr: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    op_fire && I_OP.src_mode == CRF_MODE_INDEXED_OFS && I_OP.dst_mode == CRF_MODE_DIRECT
      |=> O_SRC_ADDR == $past(O_INDEX) + $past(I_OP.offset)
          && O_DST_ADDR == {8'h00, $past(I_OP.offset[7:0])})
    else $error("Indexed or direct address formed wrongly.");

  a_signed_branch: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    I_BR_COND == CRF_BR_LESS |-> O_BRANCH_TAKE == (O_FLAGS[2] ^ O_FLAGS[7]))
    else $error("Less-than branch ignores overflow.");

endmodule

//--- verif/crf_mem_model.sv
// Byte memory standing on the core's shared address space.
`timescale 1ns/1ps
module crf_mem_model (
  // Clock and write strobe.
  input wire logic i_clock,
  input wire logic i_we,
  // Address and data.
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:65535];
  // One flat 64-Kbyte space; every address decodes to one byte.
  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end
  // Reads are combinational so the bench sees a store at once.
  assign o_rdata = mem[i_addr];
endmodule

//--- verif/crf_regs_tb.sv
// Self-checking testbench for the register file and condition flags block.
`timescale 1ns/1ps
`include "crf_consts.svh"
module crf_regs_tb;
  import crf_pkg::*;
  logic clk = 1'b0, rst = 1'b1, opv = 1'b0, bnd = 1'b0, irq = 1'b0, stk = 1'b0, we = 1'b0;
  logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0, ce = 1'b1;
  logic [7:0] awa = 8'h00, ara = 8'h00, acc, flg, mrd;
  logic [31:0] wd = 32'h0, rd;
  logic [15:0] idx, sa, da;
  logic [1:0] br, rr, r;
  logic bt, it, awr, wr, bv, arr, rv;
  crf_op_t op_r = '0;
  crf_brc_t brc = CRF_BR_GREATER;
  int miscompares = 0, cmp_count = 0;
  logic [7:0] ta [3] = '{8'h08, 8'h7f, 8'hff};
  logic [7:0] tr [3] = '{8'h10, 8'h80, 8'h00};
  logic [7:0] tf [3] = '{8'h18, 8'h9c, 8'h1b};
  // Clock at 10 MHz.
  always #50 clk = ~clk;
  crf_regs uut (.I_CLOCK(clk), .I_SYS_RST(rst), .I_CE(ce), .I_OP_VALID(opv), .I_OP(op_r),
    .I_BR_COND(brc), .I_BOUNDARY(bnd), .I_IRQ_REQ(irq), .I_REGS_STACKED(stk), .O_ACC(acc),
    .O_INDEX(idx), .O_FLAGS(flg), .O_SRC_ADDR(sa), .O_DST_ADDR(da), .O_BRANCH_TAKE(bt),
    .O_IRQ_TAKE(it), .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa), .I_WVALID(wv),
    .O_WREADY(wr), .I_WDATA(wd), .I_WSTRB(4'hf), .O_BVALID(bv), .I_BREADY(brdy),
    .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara), .O_RVALID(rv),
    .I_RREADY(rrdy), .O_RDATA(rd), .O_RRESP(rr));
  crf_mem_model mem (.i_clock(clk), .i_we(we), .i_addr(da), .i_wdata(acc), .o_rdata(mrd));
  task print_verdict;
    $display("Compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One operation pulse; results are settled one time unit after the edge.
  task op(input crf_opc_t c, input logic [15:0] d, input logic [15:0] o = 16'h0,
          input crf_mode_t s = CRF_MODE_DIRECT, input crf_mode_t m = CRF_MODE_DIRECT);
    @(posedge clk);
    op_r <= '{opc: c, data: d, offset: o, bit_sel: 3'h0, src_mode: s, dst_mode: m};
    opv <= 1'b1;
    @(posedge clk);
    opv <= 1'b0;
    #1;
  endtask
  // Handshakes are judged on pre-edge values, so no race with the slave.
  task axw(input logic [7:0] a, input logic [31:0] d);
    logic ka, kw, kb;
    @(posedge clk);
    awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; brdy <= 1'b1; kb = 1'b0;
    for (int n = 0; n < 40 && !kb; n++) begin
      @(negedge clk);
      ka = awv & awr; kw = wv & wr; kb = (bv === 1'b1); r = br;
      @(posedge clk);
      if (ka) awv <= 1'b0;
      if (kw) wv <= 1'b0;
      if (kb) brdy <= 1'b0;
    end
    if (!kb) begin miscompares++; print_verdict(); end
  endtask
  task axr(input logic [7:0] a, output logic [31:0] d);
    logic ka, kr;
    @(posedge clk);
    arv <= 1'b1; ara <= a; rrdy <= 1'b1; kr = 1'b0;
    for (int n = 0; n < 40 && !kr; n++) begin
      @(negedge clk);
      ka = arv & arr; kr = (rv === 1'b1); r = rr; d = rd;
      @(posedge clk);
      if (ka) arv <= 1'b0;
      if (kr) rrdy <= 1'b0;
    end
    if (!kr) begin miscompares++; print_verdict(); end
  endtask
  // Hang guard.
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
  initial begin
    logic [31:0] v;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    op(CRF_LDA, 16'h005a);
    op(CRF_LDHX, 16'h12ab);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    #1;
    chk("acc after reset", 8'h5a, acc);
    chk("index after reset", 16'h00ab, idx);
    chk("flags after reset", `CRF_RST_FLAGS, flg);
    // Half carry, overflow with negative, then carry with zero.
    for (int i = 0; i < 3; i++) begin
      op(CRF_LDA, {8'h00, ta[i]});
      op(CRF_ADD, 16'h0001 + (i == 0 ? 16'h0007 : 16'h0));
      chk("sum", tr[i], acc);
      chk("flags", tf[i], flg);
    end
    // N=1 V=1 Z=0: greater and greater-equal taken, the others not.
    op(CRF_LDA, 16'h007f);
    op(CRF_ADD, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) brc <= crf_brc_t'(i[1:0]);
      #1 chk("branch", {31'h0, i < 2}, bt);
    end
    op(CRF_LDA, 16'h0009);
    op(CRF_ADD, 16'h0009);
    op(CRF_DECADJ, 16'h0000);
    chk("decimal adjust", 8'h18, acc);
    op(CRF_LDHX, 16'h12ff);
    op(CRF_INCX, 16'h0000);
    chk("low byte increment", 16'h1200, idx);
    op(CRF_LDHX, 16'h1234);
    op(CRF_STA, 16'h0000, 16'h4000, CRF_MODE_INDEXED, CRF_MODE_EXTENDED);
    chk("indexed source", 16'h1234, sa);
    chk("extended destination", 16'h4000, da);
    @(posedge clk) we <= 1'b1;
    @(posedge clk) we <= 1'b0;
    #1 chk("stored byte", 8'h18, mrd);
    // With the clock enable low a load must not reach the accumulator.
    @(posedge clk) ce <= 1'b0;
    op(CRF_LDA, 16'h0033);
    chk("frozen acc", 8'h18, acc);
    @(posedge clk) ce <= 1'b1;
    // The first boundary after unmasking never takes the interrupt.
    op(CRF_UNMASK, 16'h0000);
    @(posedge clk) begin bnd <= 1'b1; irq <= 1'b1; end
    #1 chk("take after unmask", 1'b0, it);
    @(posedge clk) #1 chk("take enabled", 1'b1, it);
    @(posedge clk) begin bnd <= 1'b0; stk <= 1'b1; end
    @(posedge clk) begin stk <= 1'b0; bnd <= 1'b1; end
    #1 chk("mask after stacking", 1'b1, flg[`CRF_CC_I]);
    chk("take masked", 1'b0, it);
    @(posedge clk) begin bnd <= 1'b0; irq <= 1'b0; end
    axw(`CRF_OFS_FLAGS, 32'h00000091);
    chk("flags write resp", `CRF_RESP_OKAY, r);
    axr(`CRF_OFS_FLAGS, v);
    chk("flags read", 32'h00000091, v);
    chk("flags port", 8'h91, flg);
    axw(`CRF_OFS_STATUS, 32'h000000ff);
    axr(`CRF_OFS_STATUS, v);
    chk("status read only", 32'h0, v);
    axr(8'h10, v);
    chk("unmapped resp", `CRF_RESP_SLVERR, r);
    chk("unmapped data", 32'h0, v);
    axw(8'h10, 32'h00000001);
    chk("unmapped write resp", `CRF_RESP_SLVERR, r);
    chk("flags kept", 8'h91, flg);
    print_verdict();
  end
endmodule
